/* File: pkg/diops_pkg.sv */
// package for the digital i/o port block: widths, reset values, states
// assumes a single 100 MHz clock and an active-low asynchronous reset
package diops_pkg;
    localparam int PORT_W = 16;                      // width of one port
    localparam int NUM_PORTS = 2;                    // ports per direction
    localparam logic [15:0] OUT_RESET = 16'h0000;    // outputs after reset
    localparam logic [15:0] IN_RESET = 16'h0000;     // input view while disabled
    localparam logic [1:0] SYNC_RESET = 2'b00;       // synchroniser reset
    localparam logic MODE_RESET = 1'b0;              // bidirectional lines: input mode
    typedef logic [PORT_W-1:0] diops_word_t;
    typedef enum logic [1:0] {
        DIOPS_DISABLED = 2'b00,
        DIOPS_LIVE = 2'b01
    } diops_state_t;
endpackage

/* File: verilog/diops_in_port.sv */
// one 16-bit input port: pin synchroniser, strobe latch, enable gate
// assumes pins are asynchronous; strobe arrives already synchronised
`timescale 1ns/1ps
module diops_in_port (
    input wire logic i_clock,                      // system clock
    input wire logic i_rst_n,                      // async reset, active low
    input wire diops_pkg::diops_word_t i_pins,     // raw input pins
    input wire logic i_enable,                     // input path enabled
    input wire logic i_strobe_mode,                // latch instead of pass
    input wire logic i_strobe_rise,                // one-cycle capture pulse
    output diops_pkg::diops_word_t o_value         // value seen by host
);
    import diops_pkg::*;
    diops_word_t sync_a;
    diops_word_t sync_b;
    diops_word_t held;

    // two-flop synchroniser on the pins
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sync_a <= IN_RESET;
            sync_b <= IN_RESET;
        end else begin
            sync_a <= i_pins;
            sync_b <= sync_a;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            held <= IN_RESET;
        end else if (i_enable && i_strobe_rise) begin
            held <= sync_b;
        end
    end

    // output register: disabled, latched or transparent
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_value <= IN_RESET;
        end else if (!i_enable) begin
            o_value <= IN_RESET;
        end else if (i_strobe_mode) begin
            o_value <= held;
        end else begin
            o_value <= sync_b;
        end
    end
endmodule

/* File: verilog/diops_top.sv */
// digital i/o port block: two output ports, two input ports, strobe latch
// assumes host logic on i_clock writes outputs; pins and strobe are asynchronous
// assumes the strobe pin idles low and rises once for each snapshot
// assumes output mode is left only through the host reset
`timescale 1ns/1ps
module diops_top (
    input wire logic i_clock,                          // 100 MHz clock
    input wire logic i_rst_n,                          // host reset, active low
    input wire diops_pkg::diops_word_t i_out_data0,    // host value, output port 0
    input wire diops_pkg::diops_word_t i_out_data1,    // host value, output port 1
    input wire logic i_out_write0,                     // load output port 0
    input wire logic i_out_write1,                     // load output port 1
    input wire logic i_output_mode,                    // host selects output mode
    input wire diops_pkg::diops_word_t i_in_pins0,     // input port 0 pins
    input wire diops_pkg::diops_word_t i_in_pins1,     // input port 1 pins
    input wire logic i_strobe,                         // external strobe pin
    input wire logic i_strobe_mode,                    // host selects strobe latching
    output diops_pkg::diops_word_t o_out_pins0,        // output port 0 pins
    output diops_pkg::diops_word_t o_out_pins1,        // output port 1 pins
    output logic o_out_en,                             // drive enable of output lines
    output diops_pkg::diops_word_t o_input_port0,      // input port 0 value to host
    output diops_pkg::diops_word_t o_input_port1,      // input port 1 value to host
    output logic o_in_enabled                          // input path running
);
    import diops_pkg::*;

    // input enable state
    diops_state_t state; // input path state
    diops_state_t next_state; // state after this edge
    logic in_live; // input path enabled
    logic next_in_enabled; // host enable flag after this edge

    // strobe path
    logic [1:0] strobe_sync; // two-flop strobe synchroniser
    logic strobe_prev; // synchronised strobe, one edge old
    logic strobe_rise; // one-cycle capture pulse

    // output mode
    logic out_mode; // sticky output mode flag
    logic next_out_mode; // mode after this edge

    // per-port views
    diops_word_t out_data [NUM_PORTS]; // host values by port
    logic out_write [NUM_PORTS]; // host loads by port
    diops_word_t out_reg [NUM_PORTS]; // output port registers
    diops_word_t in_pins [NUM_PORTS]; // raw pins by port
    diops_word_t in_value [NUM_PORTS]; // port module results
    diops_word_t in_reg [NUM_PORTS]; // host-facing input registers

    always_comb begin
        next_state = state;
        unique case (state)
            DIOPS_DISABLED: begin
                next_state = DIOPS_LIVE;
            end
            DIOPS_LIVE: begin
                next_state = DIOPS_LIVE;
            end
            default: begin
                next_state = DIOPS_DISABLED;
            end
        endcase
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= DIOPS_DISABLED;
        end else begin
            state <= next_state;
        end
    end

    // enable level handed to the port modules
    assign in_live = (state == DIOPS_LIVE);

    // two-flop synchroniser on the strobe pin
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            strobe_sync <= SYNC_RESET;
        end else begin
            strobe_sync <= {strobe_sync[0], i_strobe};
        end
    end

    // previous level; reset matches the idle low strobe, so no false edge
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            strobe_prev <= SYNC_RESET[0];
        end else begin
            strobe_prev <= strobe_sync[1];
        end
    end

    assign strobe_rise = strobe_sync[1] && !strobe_prev;

    always_comb begin
        next_out_mode = out_mode | i_output_mode;
    end

    // mode flag fed back into its next value
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            out_mode <= MODE_RESET;
        end else begin
            out_mode <= next_out_mode;
        end
    end

    // drive enable, input mode after reset
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_out_en <= MODE_RESET;
        end else begin
            o_out_en <= next_out_mode;
        end
    end

    // per-port views of the host and pin inputs
    assign out_data[0] = i_out_data0;
    assign out_data[1] = i_out_data1;
    assign out_write[0] = i_out_write0;
    assign out_write[1] = i_out_write1;
    assign in_pins[0] = i_in_pins0;
    assign in_pins[1] = i_in_pins1;

    generate
        for (genvar p = 0; p < NUM_PORTS; p++) begin : g_out
            diops_word_t out_word; // output register of this port
            diops_word_t next_out_word; // value after this edge

            // load on a write pulse, hold otherwise
            always_comb begin
                next_out_word = out_word;
                if (out_write[p]) begin
                    next_out_word = out_data[p];
                end
            end

            always_ff @(posedge i_clock or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    out_word <= OUT_RESET;
                end else begin
                    out_word <= next_out_word;
                end
            end

            // port register seen by the output pins
            assign out_reg[p] = out_word;
        end
    endgenerate

    // one port module per input port
    generate
        for (genvar p = 0; p < NUM_PORTS; p++) begin : g_in
            diops_word_t host_word; // host-facing register of this port
            diops_word_t next_host_word; // value after this edge

            // synchroniser, strobe latch and enable gate
            diops_in_port u_port (
                .i_clock(i_clock),
                .i_rst_n(i_rst_n),
                .i_pins(in_pins[p]),
                .i_enable(in_live),
                .i_strobe_mode(i_strobe_mode),
                .i_strobe_rise(strobe_rise),
                .o_value(in_value[p])
            );

            // host register follows the port module
            always_comb begin
                next_host_word = in_value[p];
            end

            // host-facing register, cleared while reset is low
            always_ff @(posedge i_clock or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    host_word <= IN_RESET;
                end else begin
                    host_word <= next_host_word;
                end
            end

            // register seen by the host
            assign in_reg[p] = host_word;
        end
    endgenerate

    // top outputs straight from the port registers
    assign o_out_pins0 = out_reg[0];
    assign o_out_pins1 = out_reg[1];
    assign o_input_port0 = in_reg[0];
    assign o_input_port1 = in_reg[1];

    // host sees the running input path
    always_comb begin
        next_in_enabled = in_live;
    end

    // input path flag, low while reset is low
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_in_enabled <= 1'b0;
        end else begin
            o_in_enabled <= next_in_enabled;
        end
    end
endmodule

/* File: verif/diops_properties.sv */
// checker: timing relations at the ports of the i/o port block
// assumes it is bound into diops_top and sees its ports only
`timescale 1ns/1ps
module diops_properties (
    input wire logic i_clock, // clock
    input wire logic i_rst_n, // reset, active low
    input wire diops_pkg::diops_word_t i_out_data0, // port 0 data
    input wire logic i_out_write0, // port 0 load
    input wire logic i_output_mode, // output mode request
    input wire diops_pkg::diops_word_t i_in_pins0, // input pins 0
    input wire logic i_strobe, // strobe pin
    input wire logic i_strobe_mode, // latched view
    input wire diops_pkg::diops_word_t o_out_pins0, // output pins 0
    input wire logic o_out_en, // output drive
    input wire diops_pkg::diops_word_t o_input_port0, // host view 0
    input wire logic o_in_enabled // input path live
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    // quiet strobe in latched mode; steady pins in transparent mode
    sequence calm_s;
        i_strobe_mode && !i_strobe && o_in_enabled;
    endsequence
    sequence steady_s;
        !i_strobe_mode && o_in_enabled && $stable(i_in_pins0);
    endsequence
    chk_reset_out_low: assert property (disable iff (1'b0)
        !i_rst_n |-> o_out_pins0 == 16'h0000 && !o_out_en) else $error("outputs set in reset");
    chk_reset_in_off: assert property (disable iff (1'b0)
        !i_rst_n |-> !o_in_enabled && o_input_port0 == 16'h0000) else $error("input live in reset");
    chk_input_enable: assert property ($rose(i_rst_n) |-> ##[1:3] o_in_enabled)
        else $error("input path not enabled");
    chk_out_load: assert property (i_out_write0 |=> o_out_pins0 == $past(i_out_data0))
        else $error("port 0 not loaded");
    chk_mode_set: assert property (i_output_mode |=> o_out_en)
        else $error("output mode not set");
    chk_mode_sticky: assert property (o_out_en |=> o_out_en)
        else $error("output mode lost");
    chk_latch_hold: assert property (calm_s [*8] |-> $stable(o_input_port0))
        else $error("latched value moved");
    chk_pass_through: assert property (steady_s [*6] |-> o_input_port0 == i_in_pins0)
        else $error("pins not passed through");
endmodule
bind diops_top diops_properties diops_properties_inst (.*);

/* File: verif/diops_field.sv */
// field side model: input lines and strobe of the external devices
// assumes the bench clock; strobe stays low between requests
`timescale 1ns/1ps
module diops_field (
    input wire logic i_clock, // clock
    input wire diops_pkg::diops_word_t i_val0, // level for lines 0
    input wire diops_pkg::diops_word_t i_val1, // level for lines 1
    input wire logic i_fire, // request one strobe
    output diops_pkg::diops_word_t o_pins0, // input port 0 lines
    output diops_pkg::diops_word_t o_pins1, // input port 1 lines
    output logic o_strobe // strobe line
);
    logic [2:0] count = 3'h0;
    assign o_pins0 = i_val0;
    assign o_pins1 = i_val1;
    always @(posedge i_clock) begin
        count <= i_fire ? 3'h4 : count - {2'h0, count != 3'h0};
    end
    assign o_strobe = count > 3'h1;
endmodule

/* File: verif/dio_port_reset_strobe_test.sv */
// bench: rows of writes and pin levels, then strobe, output mode, reset
// assumes diops_top and the field model diops_field, one 100 MHz clock
`timescale 1ns/1ps
module dio_port_reset_strobe_test;
    import diops_pkg::*;
    logic i_clock = 1'b0;
    logic i_rst_n = 1'b1;
    logic w0 = 1'b0, w1 = 1'b0, om = 1'b0, sm = 1'b0, fire = 1'b0, st, en, ie;
    diops_word_t d0 = 16'h0000, d1 = 16'h0000, v0 = 16'h0000, v1 = 16'h0000;
    diops_word_t p0, p1, q0, q1, r0, r1;
    int err_total = 0, compares = 0;
    // rows: data 0, data 1, lines 0, lines 1
    diops_word_t rows [3][4] = '{'{16'hA5A5, 16'h5A5A, 16'hFFFF, 16'h0001},
        '{16'h0000, 16'hFFFF, 16'h8000, 16'h7FFE}, '{16'h1234, 16'h0001, 16'h0000, 16'hFFFF}};
    always #5 i_clock = ~i_clock;
    diops_top diops_top_inst (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_out_data0(d0),
        .i_out_data1(d1), .i_out_write0(w0), .i_out_write1(w1), .i_output_mode(om),
        .i_in_pins0(p0), .i_in_pins1(p1), .i_strobe(st), .i_strobe_mode(sm), .o_out_pins0(q0),
        .o_out_pins1(q1), .o_out_en(en), .o_input_port0(r0), .o_input_port1(r1), .o_in_enabled(ie));
    diops_field diops_field_inst (.i_clock(i_clock), .i_val0(v0), .i_val1(v1), .i_fire(fire),
        .o_pins0(p0), .o_pins1(p1), .o_strobe(st));
    // compare one word and count it
    task automatic cmp(input string n, input diops_word_t e, input diops_word_t g);
        compares++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    // wait n edges, then settle to the falling edge
    task automatic tick(input int n);
        repeat (n) @(posedge i_clock);
        @(negedge i_clock);
    endtask
    task automatic results;
        $display("errors %0d compares %0d", err_total, compares);
        if (err_total == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // reset, rows, strobe latch, output mode, second reset
    initial begin
        i_rst_n <= 1'b0;
        d0 <= 16'hFFFF;
        w0 <= 1'b1;
        v0 <= 16'h1234;
        tick(2);
        cmp("reset out", 16'h0000, q0 | q1 | {15'h0000, en});
        cmp("reset in", 16'h0000, r0 | r1 | {15'h0000, ie});
        @(posedge i_clock);
        i_rst_n <= 1'b1;
        w0 <= 1'b0;
        tick(4);
        cmp("enabled", 16'h0001, {15'h0000, ie});
        cmp("input mode", 16'h0000, {15'h0000, en});
        foreach (rows[i]) begin
            @(posedge i_clock);
            {d0, d1, v0, v1} <= {rows[i][0], rows[i][1], rows[i][2], rows[i][3]};
            {w0, w1} <= 2'h3;
            @(posedge i_clock);
            {w0, w1} <= 2'h0;
            tick(7);
            cmp("out0", rows[i][0], q0);
            cmp("out1", rows[i][1], q1);
            cmp("in0", rows[i][2], r0);
            cmp("in1", rows[i][3], r1);
        end
        @(posedge i_clock);
        {sm, fire, v0, v1} <= {2'h3, 16'hC3C3, 16'h3C3C};
        @(posedge i_clock);
        fire <= 1'b0;
        tick(10);
        cmp("latch0", 16'hC3C3, r0);
        cmp("latch1", 16'h3C3C, r1);
        @(posedge i_clock);
        v0 <= 16'h0F0F;
        tick(10);
        cmp("held", 16'hC3C3, r0);
        @(posedge i_clock);
        {fire, om} <= 2'h3;
        @(posedge i_clock);
        {fire, om} <= 2'h0;
        tick(10);
        cmp("relatch", 16'h0F0F, r0);
        cmp("output mode", 16'h0001, {15'h0000, en});
        @(posedge i_clock);
        i_rst_n <= 1'b0;
        tick(3);
        cmp("rerun out", 16'h0000, q0 | q1 | {15'h0000, en});
        cmp("rerun in", 16'h0000, r0 | r1 | {15'h0000, ie});
        @(posedge i_clock);
        i_rst_n <= 1'b1;
        tick(4);
        cmp("re-enabled", 16'h0001, {15'h0000, ie});
        cmp("mode after reset", 16'h0000, {15'h0000, en});
        cmp("latch after reset", 16'h0000, r0);
        results();
    end
endmodule
